// ### logic/rcbl_pkg.sv
/*
  Constants, register map and field layout of the refresh event counter
  and byte-lane steering block.
  Assumes one 100 MHz bus clock and AHB-Lite word access from the CPU.
*/
package rcbl_pkg;
  // register byte offsets (haddr[7:0])
  localparam logic [7:0] OFS_CTRL_STATUS = 8'h00;
  localparam logic [7:0] OFS_TIMER_COUNT = 8'h04;
  localparam logic [7:0] OFS_TIME_CONST = 8'h08;
  localparam logic [7:0] OFS_EVENT_COUNT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_EXT_CTRL = 8'h18;
  localparam logic [7:0] OFS_EXT_WDATA = 8'h1c;
  localparam logic [7:0] OFS_EXT_RDATA = 8'h20;
  localparam logic [7:0] OFS_EXT_STATUS = 8'h24;
  // write keys
  localparam logic [7:0] KEY_BYTE = 8'ha5;
  localparam logic [5:0] KEY_COUNT = 6'h29;
  // refresh counter
  localparam int CNT_W = 10;
  localparam logic [CNT_W:0] LIMIT_1024 = 11'h400;
  localparam logic [CNT_W:0] LIMIT_512 = 11'h200;
  // control/status bit positions
  localparam int CS_CMF = 7;
  localparam int CS_CMIE = 6;
  localparam int CS_CKS = 3;
  localparam int CS_OVF = 2;
  localparam int CS_OVIE = 1;
  localparam int CS_OVERFLOW_LIMIT_SELECT = 0;
  // interrupt status bits
  localparam int IRQ_W = 5;
  localparam int IRQ_OVF = 0;
  localparam int IRQ_CMF = 1;
  localparam int IRQ_DONE = 2;
  localparam int IRQ_KEY = 3;
  localparam int IRQ_BADW = 4;
  // external access control fields
  localparam int EC_ADDR = 0;
  localparam int EC_SIZE = 2;
  localparam int EC_WIDTH = 4;
  localparam int EC_WRITE = 6;
  localparam int EC_GO = 8;
  localparam int EC_KIND = 9;
  localparam logic [1:0] KIND_NORMAL = 2'h0;
  localparam logic [1:0] KIND_DRAM = 2'h1;
  localparam logic [1:0] KIND_SDRAM = 2'h2;
  localparam logic [1:0] KIND_PCMCIA = 2'h3;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  // pin synchroniser latency seen by the sequencer
  localparam logic [1:0] SYNC_WAIT = 2'h2;
  localparam logic [1:0] POR_SETTLE = 2'h2;
  localparam logic [2:0] HSIZE_HALF = 3'h1;
  typedef enum logic [3:0] {
    RCBL_IDLE = 4'h1,
    RCBL_DRIVE = 4'h2,
    RCBL_WAIT = 4'h4,
    RCBL_CAPT = 4'h8
  } rcbl_state_t;
endpackage : rcbl_pkg

// ### logic/rcbl_top.sv
/*
  Refresh event counter with keyed registers, refresh timer, interrupt
  status, and an external access sequencer steering bytes onto lanes.
  Assumes hresetn is the power-on reset; manual reset, standby, endian
  and data pins arrive asynchronously and are synchronised here.
*/
// The AHB-Lite register port and the register offsets were chosen for this implementation.
//
// Behaviour
// - ten-bit count increments on timer match
// - beyond limit: set overflow flag, clear count
// - limit select 0 is 1024, 1 is 512
// - power-on reset clears count; others retain
// - count register 16 bits, upper six zero
// - count write carries key 101001 on top
// - timer register writes carry key 10100101
// - keyed reads 16 bits, undefined bits zero
// - endian pin sampled at power-on reset
// - big endian: address zero is MSB
// - device widths allowed per memory kind
// - wide access split into narrower consecutive accesses
// - 32-bit big byte lanes and strobes
// - 32-bit big word and longword lanes
// - 16-bit big byte and word lanes
// - 16-bit big longword: two accesses, upper first
`timescale 1ns/1ps
module rcbl_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic irq,
  input wire logic manual_reset_n,
  input wire logic standby,
  input wire logic endian_select_pin,
  input wire logic [31:0] ext_data_in,
  output logic [31:0] ext_data_out,
  output logic [1:0] ext_addr,
  output logic ext_cycle,
  output logic ext_read_n,
  output logic lane3_write_strobe_n,
  output logic lane2_write_strobe_n,
  output logic lane1_write_strobe_n,
  output logic lane0_write_strobe_n
);
  ////////////////////////////////////////////////////////////////////////
  logic mrst_s1, mrst_s2, stby_s1, stby_s2, end_s1, end_s2;
  logic [31:0] din_s1, din_s2;
  logic [1:0] por_cnt;
  logic big_endian, endian_done;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mrst_s1 <= 1'b1;
      mrst_s2 <= 1'b1;
      stby_s1 <= 1'b0;
      stby_s2 <= 1'b0;
      end_s1 <= 1'b0;
      end_s2 <= 1'b0;
      din_s1 <= 32'h0000_0000;
      din_s2 <= 32'h0000_0000;
    end else begin
      mrst_s1 <= manual_reset_n;
      mrst_s2 <= mrst_s1;
      stby_s1 <= standby;
      stby_s2 <= stby_s1;
      end_s1 <= endian_select_pin;
      end_s2 <= end_s1;
      din_s1 <= ext_data_in;
      din_s2 <= din_s1;
    end
  end

  // endian caught once, after the synchroniser has settled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      por_cnt <= 2'h0;
      big_endian <= 1'b1;
      endian_done <= 1'b0;
    end else if (!endian_done) begin
      if (por_cnt == rcbl_pkg::POR_SETTLE) begin
        big_endian <= ~end_s2;
        endian_done <= 1'b1;
      end else begin
        por_cnt <= 2'(por_cnt + 2'h1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus slave: writes land in the data phase, reads take one wait state
  logic wr_pend, rd_pend, wide_ok;
  logic [7:0] ph_addr;
  logic addr_take;
  assign addr_take = hsel & htrans[1] & hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      wide_ok <= 1'b0;
      ph_addr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      if (hready) begin
        wr_pend <= addr_take & hwrite;
        rd_pend <= addr_take & ~hwrite;
        wide_ok <= (hsize >= rcbl_pkg::HSIZE_HALF);
        if (addr_take) begin
          ph_addr <= haddr[7:0];
        end
      end else begin
        rd_pend <= 1'b0;
      end
      hreadyout <= ~(addr_take & ~hwrite & hready);
    end
  end

  logic key_byte_ok, key_count_ok, wr_keyed, wr_count;
  logic wr_cs, wr_tc, wr_tk, wr_ec, key_bad;
  assign key_byte_ok = hwdata[15:8] == rcbl_pkg::KEY_BYTE;
  assign key_count_ok = hwdata[15:10] == rcbl_pkg::KEY_COUNT;
  assign wr_keyed = wr_pend & wide_ok;
  assign wr_cs = wr_keyed & key_byte_ok & (ph_addr == rcbl_pkg::OFS_CTRL_STATUS);
  assign wr_tc = wr_keyed & key_byte_ok & (ph_addr == rcbl_pkg::OFS_TIMER_COUNT);
  assign wr_tk = wr_keyed & key_byte_ok & (ph_addr == rcbl_pkg::OFS_TIME_CONST);
  assign wr_count = wr_keyed & key_count_ok & (ph_addr == rcbl_pkg::OFS_EVENT_COUNT);
  assign wr_ec = wr_pend & (ph_addr == rcbl_pkg::OFS_EXT_CTRL);
  // keyed writes whose key is wrong change nothing, only flag the attempt
  assign key_bad = wr_pend & (
    ((ph_addr == rcbl_pkg::OFS_CTRL_STATUS || ph_addr == rcbl_pkg::OFS_TIMER_COUNT ||
      ph_addr == rcbl_pkg::OFS_TIME_CONST) && !(key_byte_ok && wide_ok)) ||
    (ph_addr == rcbl_pkg::OFS_EVENT_COUNT && !(key_count_ok && wide_ok)));

  ////////////////////////////////////////////////////////////////////////
  // refresh timer and event counter
  logic [7:0] ctrl_status, timer_count, time_const;
  logic [rcbl_pkg::CNT_W-1:0] event_count;
  logic [11:0] presc, div_mask;
  logic tick, match, over;
  logic [rcbl_pkg::CNT_W:0] count_inc, limit;

  always_comb begin
    unique case (ctrl_status[rcbl_pkg::CS_CKS +: 3])
      3'h1: div_mask = 12'h003;
      3'h2: div_mask = 12'h00f;
      3'h3: div_mask = 12'h03f;
      3'h4: div_mask = 12'h0ff;
      3'h5: div_mask = 12'h3ff;
      3'h6: div_mask = 12'h7ff;
      3'h7: div_mask = 12'hfff;
      default: div_mask = 12'h000;
    endcase
  end

  assign tick = (div_mask != 12'h000) & ((presc & div_mask) == div_mask) & ~stby_s2;
  assign match = tick & (timer_count == time_const);
  assign count_inc = {1'b0, event_count} + 11'h001;
  assign limit = ctrl_status[rcbl_pkg::CS_OVERFLOW_LIMIT_SELECT] ? rcbl_pkg::LIMIT_512 : rcbl_pkg::LIMIT_1024;
  assign over = match & (count_inc >= limit);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc <= 12'h000;
    end else if (!stby_s2) begin
      presc <= 12'(presc + 12'h001);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_count <= 8'h00;
      time_const <= 8'h00;
    end else begin
      if (wr_tc) begin
        timer_count <= hwdata[7:0];
      end else if (match) begin
        timer_count <= 8'h00;
      end else if (tick) begin
        timer_count <= 8'(timer_count + 8'h01);
      end
      if (wr_tk) begin
        time_const <= hwdata[7:0];
      end
    end
  end

  // of the resets, only hresetn clears the count; manual reset and standby leave it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      event_count <= 10'h000;
    end else if (wr_count) begin
      event_count <= hwdata[rcbl_pkg::CNT_W-1:0];
    end else if (over) begin
      event_count <= 10'h000;
    end else if (match) begin
      event_count <= count_inc[rcbl_pkg::CNT_W-1:0];
    end
  end

  // flags: writing 0 clears, writing 1 keeps, a set in the same cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_status <= 8'h00;
    end else begin
      if (wr_cs) begin
        ctrl_status[rcbl_pkg::CS_CMIE] <= hwdata[rcbl_pkg::CS_CMIE];
        ctrl_status[rcbl_pkg::CS_CKS +: 3] <= hwdata[rcbl_pkg::CS_CKS +: 3];
        ctrl_status[rcbl_pkg::CS_OVIE] <= hwdata[rcbl_pkg::CS_OVIE];
        ctrl_status[rcbl_pkg::CS_OVERFLOW_LIMIT_SELECT] <= hwdata[rcbl_pkg::CS_OVERFLOW_LIMIT_SELECT];
      end
      ctrl_status[rcbl_pkg::CS_CMF] <= match |
        (ctrl_status[rcbl_pkg::CS_CMF] & ~(wr_cs & ~hwdata[rcbl_pkg::CS_CMF]));
      ctrl_status[rcbl_pkg::CS_OVF] <= over |
        (ctrl_status[rcbl_pkg::CS_OVF] & ~(wr_cs & ~hwdata[rcbl_pkg::CS_OVF]));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // external access configuration and sequencer
  rcbl_pkg::rcbl_state_t state;
  logic [1:0] cfg_addr, cfg_size, cfg_width, cfg_kind, beat, wait_cnt;
  logic cfg_write, start, legal, seq_done;
  logic [31:0] cfg_wdata, rd_acc;
  logic [1:0] l2b, dev_mask, acc_mask, last_beat, beat_addr;
  logic [3:0] lane_act;
  logic [1:0] lane_src [4];

  // widths each memory kind can drive, plus natural alignment
  always_comb begin
    unique case (hwdata[rcbl_pkg::EC_KIND +: 2])
      rcbl_pkg::KIND_NORMAL: legal = hwdata[rcbl_pkg::EC_WIDTH +: 2] <= rcbl_pkg::SZ_LONG;
      rcbl_pkg::KIND_DRAM: legal = hwdata[rcbl_pkg::EC_WIDTH +: 2] == rcbl_pkg::SZ_WORD ||
        hwdata[rcbl_pkg::EC_WIDTH +: 2] == rcbl_pkg::SZ_LONG;
      rcbl_pkg::KIND_SDRAM: legal = hwdata[rcbl_pkg::EC_WIDTH +: 2] == rcbl_pkg::SZ_LONG;
      rcbl_pkg::KIND_PCMCIA: legal = hwdata[rcbl_pkg::EC_WIDTH +: 2] <= rcbl_pkg::SZ_WORD;
    endcase
    if (hwdata[rcbl_pkg::EC_SIZE +: 2] > rcbl_pkg::SZ_LONG) begin
      legal = 1'b0;
    end
    if ((hwdata[rcbl_pkg::EC_ADDR +: 2] & 2'((3'h1 << hwdata[rcbl_pkg::EC_SIZE +: 2]) - 3'h1)) != 2'h0) begin
      legal = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_addr <= 2'h0;
      cfg_size <= 2'h0;
      cfg_width <= 2'h0;
      cfg_kind <= 2'h0;
      cfg_write <= 1'b0;
      cfg_wdata <= 32'h0000_0000;
      start <= 1'b0;
    end else begin
      start <= 1'b0;
      if (wr_pend && ph_addr == rcbl_pkg::OFS_EXT_WDATA && state == rcbl_pkg::RCBL_IDLE) begin
        cfg_wdata <= hwdata;
      end
      if (wr_ec && state == rcbl_pkg::RCBL_IDLE && !start) begin
        cfg_addr <= hwdata[rcbl_pkg::EC_ADDR +: 2];
        cfg_size <= hwdata[rcbl_pkg::EC_SIZE +: 2];
        cfg_width <= hwdata[rcbl_pkg::EC_WIDTH +: 2];
        cfg_kind <= hwdata[rcbl_pkg::EC_KIND +: 2];
        cfg_write <= hwdata[rcbl_pkg::EC_WRITE];
        start <= hwdata[rcbl_pkg::EC_GO] & legal & endian_done;
      end
    end
  end

  // beat geometry: bytes per beat is the smaller of access and device
  assign l2b = (cfg_size < cfg_width) ? cfg_size : cfg_width;
  assign dev_mask = 2'((3'h1 << cfg_width) - 3'h1);
  assign acc_mask = 2'((3'h1 << cfg_size) - 3'h1);
  assign last_beat = 2'((3'h1 << (cfg_size - l2b)) - 3'h1);
  assign beat_addr = 2'(cfg_addr + (beat << l2b));

  always_comb begin
    logic [1:0] a, off, ln;
    a = 2'h0;
    off = 2'h0;
    ln = 2'h0;
    lane_act = 4'h0;
    for (int j = 0; j < 4; j++) begin
      lane_src[j] = 2'h0;
    end
    for (int k = 0; k < 4; k++) begin
      if (k < (1 << l2b)) begin
        a = 2'(beat_addr + 2'(k));
        off = 2'(a - cfg_addr);
        // big endian: low address on the high lane and high data byte
        ln = big_endian ? 2'(dev_mask - (a & dev_mask)) : (a & dev_mask);
        lane_act[ln] = 1'b1;
        lane_src[ln] = big_endian ? 2'(acc_mask - off) : off;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= rcbl_pkg::RCBL_IDLE;
      beat <= 2'h0;
      wait_cnt <= 2'h0;
      seq_done <= 1'b0;
    end else if (!mrst_s2) begin
      state <= rcbl_pkg::RCBL_IDLE;
      beat <= 2'h0;
      seq_done <= 1'b0;
    end else begin
      seq_done <= 1'b0;
      unique case (state)
        rcbl_pkg::RCBL_IDLE: begin
          beat <= 2'h0;
          if (start) begin
            state <= rcbl_pkg::RCBL_DRIVE;
          end
        end
        rcbl_pkg::RCBL_DRIVE: begin
          wait_cnt <= 2'h1;
          state <= rcbl_pkg::RCBL_WAIT;
        end
        rcbl_pkg::RCBL_WAIT: begin
          wait_cnt <= 2'(wait_cnt + 2'h1);
          if (wait_cnt == rcbl_pkg::SYNC_WAIT) begin
            state <= rcbl_pkg::RCBL_CAPT;
          end
        end
        rcbl_pkg::RCBL_CAPT: begin
          if (beat == last_beat) begin
            state <= rcbl_pkg::RCBL_IDLE;
            seq_done <= 1'b1;
          end else begin
            beat <= 2'(beat + 2'h1);
            state <= rcbl_pkg::RCBL_DRIVE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_acc <= 32'h0000_0000;
    end else if (state == rcbl_pkg::RCBL_IDLE && start) begin
      rd_acc <= 32'h0000_0000;
    end else if (state == rcbl_pkg::RCBL_CAPT && !cfg_write) begin
      for (int j = 0; j < 4; j++) begin
        if (lane_act[j]) begin
          rd_acc[lane_src[j]*8 +: 8] <= din_s2[j*8 +: 8];
        end
      end
    end
  end

  // pin outputs follow the beat for DRIVE and WAIT, one cycle behind
  logic beat_on;
  assign beat_on = (state == rcbl_pkg::RCBL_DRIVE || state == rcbl_pkg::RCBL_WAIT) & mrst_s2;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_data_out <= 32'h0000_0000;
      ext_addr <= 2'h0;
      ext_cycle <= 1'b0;
      ext_read_n <= 1'b1;
      lane3_write_strobe_n <= 1'b1;
      lane2_write_strobe_n <= 1'b1;
      lane1_write_strobe_n <= 1'b1;
      lane0_write_strobe_n <= 1'b1;
    end else begin
      for (int j = 0; j < 4; j++) begin
        ext_data_out[j*8 +: 8] <= (beat_on && cfg_write && lane_act[j]) ?
          cfg_wdata[lane_src[j]*8 +: 8] : 8'h00;
      end
      ext_addr <= beat_on ? beat_addr : 2'h0;
      ext_cycle <= beat_on;
      ext_read_n <= ~(beat_on & ~cfg_write);
      lane3_write_strobe_n <= ~(beat_on & cfg_write & lane_act[3]);
      lane2_write_strobe_n <= ~(beat_on & cfg_write & lane_act[2]);
      lane1_write_strobe_n <= ~(beat_on & cfg_write & lane_act[1]);
      lane0_write_strobe_n <= ~(beat_on & cfg_write & lane_act[0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt status (write one to clear, set wins) and mask
  logic [rcbl_pkg::IRQ_W-1:0] irq_status, irq_mask, irq_set, irq_gate;
  logic bad_start;
  assign bad_start = wr_ec & hwdata[rcbl_pkg::EC_GO] & ~legal & (state == rcbl_pkg::RCBL_IDLE);
  always_comb begin
    irq_set = '0;
    irq_set[rcbl_pkg::IRQ_OVF] = over;
    irq_set[rcbl_pkg::IRQ_CMF] = match;
    irq_set[rcbl_pkg::IRQ_DONE] = seq_done;
    irq_set[rcbl_pkg::IRQ_KEY] = key_bad;
    irq_set[rcbl_pkg::IRQ_BADW] = bad_start;
    irq_gate = irq_mask;
    irq_gate[rcbl_pkg::IRQ_OVF] = irq_mask[rcbl_pkg::IRQ_OVF] & ctrl_status[rcbl_pkg::CS_OVIE];
    irq_gate[rcbl_pkg::IRQ_CMF] = irq_mask[rcbl_pkg::IRQ_CMF] & ctrl_status[rcbl_pkg::CS_CMIE];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= '0;
      irq_mask <= '0;
      irq <= 1'b0;
    end else begin
      if (wr_pend && ph_addr == rcbl_pkg::OFS_IRQ_MASK) begin
        irq_mask <= hwdata[rcbl_pkg::IRQ_W-1:0];
      end
      if (wr_pend && ph_addr == rcbl_pkg::OFS_IRQ_STATUS) begin
        irq_status <= (irq_status & ~hwdata[rcbl_pkg::IRQ_W-1:0]) | irq_set;
      end else begin
        irq_status <= irq_status | irq_set;
      end
      irq <= |(irq_status & irq_gate);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux: keyed registers return 16 bits with unused bits zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_pend) begin
      unique case (ph_addr)
        rcbl_pkg::OFS_CTRL_STATUS: hrdata <= {24'h00_0000, ctrl_status};
        rcbl_pkg::OFS_TIMER_COUNT: hrdata <= {24'h00_0000, timer_count};
        rcbl_pkg::OFS_TIME_CONST: hrdata <= {24'h00_0000, time_const};
        rcbl_pkg::OFS_EVENT_COUNT: hrdata <= {22'h0_0000, event_count};
        rcbl_pkg::OFS_IRQ_STATUS: hrdata <= {27'h00_0000, irq_status};
        rcbl_pkg::OFS_IRQ_MASK: hrdata <= {27'h00_0000, irq_mask};
        rcbl_pkg::OFS_EXT_CTRL: hrdata <= {21'h0_0000, cfg_kind, 2'h0, cfg_write, cfg_width,
          cfg_size, cfg_addr};
        rcbl_pkg::OFS_EXT_WDATA: hrdata <= cfg_wdata;
        rcbl_pkg::OFS_EXT_RDATA: hrdata <= rd_acc;
        rcbl_pkg::OFS_EXT_STATUS: hrdata <= {29'h000_0000, endian_done, big_endian,
          state != rcbl_pkg::RCBL_IDLE};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule : rcbl_top

// ### verification/rcbl_asserts.sv
/* Checker on the top ports: register read width and lane strobe placement.
   Assumes hready is fed back from hreadyout by the bench. */
`timescale 1ns/1ps
module rcbl_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic ext_cycle,
  input wire logic ext_read_n,
  input wire logic [1:0] ext_addr,
  input wire logic [31:0] ext_data_out,
  input wire logic lane3_write_strobe_n,
  input wire logic lane2_write_strobe_n,
  input wire logic lane1_write_strobe_n,
  input wire logic lane0_write_strobe_n
);
  logic rd_pend;
  logic [7:0] rd_addr;
  logic [3:0] stb_n;
  assign stb_n = {lane3_write_strobe_n, lane2_write_strobe_n, lane1_write_strobe_n, lane0_write_strobe_n};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pend <= 1'h0;
      rd_addr <= 8'h00;
    end else if (hsel && htrans[1] && hready && !hwrite) begin
      rd_pend <= 1'h1;
      rd_addr <= haddr[7:0];
    end else if (hreadyout) begin
      rd_pend <= 1'h0;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence beat_s;
    ext_cycle [*3] ##1 !ext_cycle;
  endsequence
  AST_BEAT_LEN: assert property ($rose(ext_cycle) |-> beat_s) else $error("beat length wrong");
  AST_IDLE_STB: assert property ((!ext_cycle || !ext_read_n) |-> stb_n == 4'hf) else $error("stray strobe");
  AST_LANE3: assert property (!lane3_write_strobe_n |-> ext_addr == 2'h0) else $error("lane3 addr");
  AST_LANE2: assert property (stb_n == 4'hb |-> ext_addr == 2'h1) else $error("lane2 addr");
  AST_LANE0: assert property (stb_n == 4'he |-> ext_addr[0]) else $error("lane0 addr");
  AST_LANE1: assert property (stb_n == 4'hd |-> !ext_addr[0]) else $error("lane1 addr");
  AST_PAIR: assert property ((stb_n[3:0] ==? 4'b0??0 || stb_n ==? 4'b?00?) |-> stb_n == 4'h0)
    else $error("strobe pair");
  AST_DATA_IDLE: assert property ((ext_cycle && ext_read_n && lane3_write_strobe_n) |-> ext_data_out[31:24] == 8'h00)
    else $error("idle lane data");
  AST_CNT_READ: assert property ((rd_pend && hreadyout && rd_addr == rcbl_pkg::OFS_EVENT_COUNT) |-> hrdata[31:10] == 0)
    else $error("count upper bits");
  AST_KEY_READ: assert property ((rd_pend && hreadyout && rd_addr inside {8'h00, 8'h04, 8'h08}) |-> hrdata[31:8] == 0)
    else $error("keyed upper bits");
endmodule : rcbl_asserts
bind rcbl_top rcbl_asserts u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hrdata,
  .ext_cycle, .ext_read_n, .ext_addr, .ext_data_out, .lane3_write_strobe_n, .lane2_write_strobe_n,
  .lane1_write_strobe_n, .lane0_write_strobe_n);

// ### verification/rcbl_ext_mem.sv
/* Big-endian external memory of four bytes, 32 or 16 bits wide.
   Assumes dev16 is set by the bench before an access starts. */
`timescale 1ns/1ps
module rcbl_ext_mem (
  input wire logic hclk,
  input wire logic dev16,
  input wire logic ext_cycle,
  input wire logic ext_read_n,
  input wire logic [1:0] ext_addr,
  input wire logic [31:0] ext_data_out,
  input wire logic [3:0] stb_n,
  output logic [31:0] ext_data_in
);
  logic [7:0] m [0:3];
  logic [31:0] last = 32'h0000_0000;
  logic [1:0] a;
  assign a = {ext_addr[1], 1'b0};
  always @(posedge hclk) begin
    last <= ext_data_in;
    for (int i = 0; i < 4; i++) begin
      if (!stb_n[i] && !dev16) m[3-i] <= ext_data_out[8*i+:8];
      if (!stb_n[i] && dev16 && i < 2) m[a+2'(1-i)] <= ext_data_out[8*i+:8];
    end
  end
  // released bus shows inverted last value
  always_comb begin
    ext_data_in = ~last;
    if (ext_cycle && !ext_read_n && !dev16) ext_data_in = {m[0], m[1], m[2], m[3]};
    if (ext_cycle && !ext_read_n && dev16) ext_data_in[15:0] = {m[a], m[a+2'h1]};
  end
endmodule : rcbl_ext_mem

// ### verification/tb.sv
/* Self-checking bench: keyed registers, overflow, interrupt, lane steering.
   Assumes the partner memory and the bound checker. */
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] CNT = rcbl_pkg::OFS_EVENT_COUNT;
  localparam logic [7:0] CS = rcbl_pkg::OFS_CTRL_STATUS;
  localparam logic [7:0] TC = rcbl_pkg::OFS_TIME_CONST;
  localparam logic [7:0] IST = rcbl_pkg::OFS_IRQ_STATUS;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp, irq;
  logic manual_reset_n = 1, standby = 0, endian_select_pin = 0, dev16 = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, ext_data_in, ext_data_out, rs, v, lw;
  logic [1:0] ext_addr;
  logic ext_cycle, ext_read_n, lane3_write_strobe_n, lane2_write_strobe_n, lane1_write_strobe_n, lane0_write_strobe_n;
  int failures = 0, comparisons = 0, n;
  always #5 hclk = ~hclk;
  assign hready = hreadyout;
  rcbl_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata,
    .hresp, .irq, .manual_reset_n, .standby, .endian_select_pin, .ext_data_in, .ext_data_out, .ext_addr, .ext_cycle,
    .ext_read_n, .lane3_write_strobe_n, .lane2_write_strobe_n, .lane1_write_strobe_n, .lane0_write_strobe_n);
  rcbl_ext_mem u_mem (.hclk, .dev16, .ext_cycle, .ext_read_n, .ext_addr, .ext_data_out, .ext_data_in,
    .stb_n({lane3_write_strobe_n, lane2_write_strobe_n, lane1_write_strobe_n, lane0_write_strobe_n}));
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wrdy;
    logic ok;
    do begin
      @(negedge hclk);
      ok = hready;
      rs = hrdata;
      @(posedge hclk);
      n++;
    end while (ok !== 1'b1 && n < 40);
    if (n >= 40) chk("bus wait", 1, 0);
    if (n >= 40) stop_test();
  endtask : wrdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [2:0] sz);
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    hsize <= sz;
    wrdy();
    htrans <= 2'h0;
    hwdata <= d;
    wrdy();
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 3'h2);
  endtask : wr
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, 3'h2);
    chk(nm, e, rs);
  endtask : rdchk
  task automatic poll(input logic [7:0] a, input int b, input logic val);
    for (int i = 0; i < 40; i++) begin
      bus(1'b0, a, 32'h0000_0000, 3'h2);
      if (rs[b] === val) return;
    end
    chk("poll", 1, 0);
    stop_test();
  endtask : poll
  function automatic logic [31:0] ectl(logic [1:0] a, logic [1:0] sz, logic [1:0] wd, logic w, logic [1:0] k);
    return {21'h0_0000, k, 1'b1, 1'b0, w, wd, sz, a};
  endfunction : ectl
  function automatic logic [31:0] bigsl(logic [31:0] l, int a, int nb);
    return (l >> (8 * (4 - a - nb))) & (32'hffff_ffff >> (32 - 8 * nb));
  endfunction : bigsl
  task automatic ext(input logic w, input logic [1:0] a, input logic [1:0] sz, input logic [1:0] wd, input logic [31:0] d);
    if (w) wr(rcbl_pkg::OFS_EXT_WDATA, d);
    wr(rcbl_pkg::OFS_EXT_CTRL, ectl(a, sz, wd, w, rcbl_pkg::KIND_NORMAL));
    poll(rcbl_pkg::OFS_EXT_STATUS, 0, 1'b0);
    if (!w) bus(1'b0, rcbl_pkg::OFS_EXT_RDATA, 32'h0000_0000, 3'h2);
  endtask : ext
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    v = $urandom(49530);
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk("count reset", CNT, 32'h0000_0000);
    rdchk("unmapped", 8'h3c, 32'h0000_0000);
    chk("hresp", 0, hresp);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      v = $urandom & 32'h0000_03ff;
      wr(CNT, {16'h0000, 6'h29, v[9:0]});
      rdchk("count key", CNT, v);
      wr(CNT, {16'h0000, 6'h28, ~v[9:0]});
      rdchk("count bad key", CNT, v);
      bus(1'b1, CNT, {16'h0000, 6'h29, ~v[9:0]}, 3'h0);
      rdchk("count byte write", CNT, v);
      wr(TC, {16'h0000, 8'h5a, v[7:0]});
      wr(TC, {16'h0000, 8'ha5, v[7:0]});
      rdchk("time const", TC, v & 32'h0000_00ff);
    end
    bus(1'b0, IST, 32'h0000_0000, 3'h2);
    chk("key flag", 1, rs[3]);
    $display("test keys done");
    for (int l = 1; l >= 0; l--) begin
      wr(rcbl_pkg::OFS_IRQ_MASK, l);
      wr(CS, {16'h0000, 8'ha5, 7'h00, l[0]});
      wr(TC, {16'h0000, 8'ha5, 8'h01});
      wr(CNT, {16'h0000, 6'h29, 10'(l ? 510 : 1022)});
      wr(CS, {16'h0000, 8'ha5, 8'h0a | l[7:0]});
      poll(CS, 2, 1'b1);
      chk("irq level", l, irq);
      wr(CS, {16'h0000, 8'ha5, 7'h00, l[0]});
      bus(1'b0, CNT, 32'h0000_0000, 3'h2);
      chk("count wrap", 1, rs < 2);
      lw = rs;
      wr(IST, 32'h0000_0001);
      rdchk("irq cleared", IST, 32'h0000_000a);
      chk("irq low", 0, irq);
    end
    manual_reset_n <= 1'b0;
    standby <= 1'b1;
    repeat (4) @(posedge hclk);
    manual_reset_n <= 1'b1;
    standby <= 1'b0;
    repeat (4) @(posedge hclk);
    rdchk("count kept", CNT, lw);
    $display("test overflow done");
    for (int k = 1; k < 4; k++) begin
      wr(rcbl_pkg::OFS_EXT_CTRL, ectl(2'h0, rcbl_pkg::SZ_BYTE, 2'(k - 1), 1'b0, 2'(k)));
      bus(1'b0, IST, 32'h0000_0000, 3'h2);
      chk("bad width", 1, rs[4]);
      wr(IST, 32'h0000_0010);
    end
    poll(rcbl_pkg::OFS_EXT_STATUS, 2, 1'b1);
    chk("big endian", 1, rs[1]);
    for (int d = 0; d < 2; d++) begin
      dev16 <= d[0];
      lw = $urandom;
      ext(1'b1, 2'h0, rcbl_pkg::SZ_LONG, 2'(2 - d), lw);
      for (int a = 0; a < 4; a++) begin
        ext(1'b0, 2'(a), rcbl_pkg::SZ_BYTE, 2'(2 - d), 0);
        chk("byte read", bigsl(lw, a, 1), rs);
        if (a[0]) continue;
        ext(1'b0, 2'(a), rcbl_pkg::SZ_WORD, 2'(2 - d), 0);
        chk("word read", bigsl(lw, a, 2), rs);
      end
      v = $urandom & 32'h0000_03ff;
      ext(1'b1, v[9:8], rcbl_pkg::SZ_BYTE, 2'(2 - d), v);
      lw[31-8*v[9:8]-:8] = v[7:0];
      ext(1'b0, 2'h0, rcbl_pkg::SZ_LONG, 2'(2 - d), 0);
      chk("long read", lw, rs);
    end
    $display("test lanes done");
    stop_test();
  end
endmodule : tb
